// ---- rtl/wdr_pkg.sv ----
// constants and types for the watchdog reset unit
// Operation
// - wrong restart key raises internal reset
// - reset deferred until source clock runs
// - restart register reads back fixed value
// - non-stoppable option: counting never halts
// - overflow in stop mode raises reset
// - stoppable option: halt/stop suspend counting
// - resume on previously selected clock
// - count is held across halt/stop
// - second mode write raises reset, except one clearing the stop bit while halted
// - clearing clock stop bit restarts nothing
package wdr_pkg;
   localparam logic [7:0] WDR_RESTART_KEY = 8'hAC;
   localparam logic [7:0] WDR_RESTART_READ = 8'h9A;
   // mode register: [7:5] fixed pattern, [4] clock stop, [3] source, [2:0] interval
   localparam logic [7:0] WDR_MODE_RST = 8'h67;
   localparam int WDR_MODE_STOP_BIT = 4;
   localparam int WDR_MODE_SRC_BIT = 3;
   localparam int WDR_MODE_SEL_LSB = 0;
   localparam int WDR_CNT_W = 18;
   localparam int WDR_CNT_BASE = 10;
   localparam logic [WDR_CNT_W-1:0] WDR_CNT_ZERO = 18'h00000;

   typedef enum logic [2:0] {
      WDR_ST_RUN = 3'b001,
      WDR_ST_HALTED = 3'b010,
      WDR_ST_PEND = 3'b100
   } wdr_state_t;

   // last count of the interval picked by the 3-bit select
   function automatic logic [WDR_CNT_W-1:0] wdr_limit(input logic [2:0] sel);
      logic [WDR_CNT_W-1:0] one;
      one = 18'h00001;
      wdr_limit = (one << (WDR_CNT_BASE + int'(sel))) - one;
   endfunction
endpackage

// ---- rtl/wdr_counter.sv ----
// interval counter of the watchdog reset unit
`timescale 1ns/1ps
module wdr_counter
   import wdr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_clr,
   input wire logic i_en,
   input wire logic [2:0] i_sel,
   output logic [WDR_CNT_W-1:0] o_count,
   output logic o_ovf
);
   logic [WDR_CNT_W-1:0] next_count;
   logic next_ovf;

   // clear wins, otherwise advance and wrap at the selected limit
   always_comb begin
      next_count = o_count;
      next_ovf = 1'b0;
      if (i_clr) begin
         next_count = WDR_CNT_ZERO;
      end else if (i_en) begin
         if (o_count >= wdr_limit(i_sel)) begin
            next_count = WDR_CNT_ZERO;
            next_ovf = 1'b1;
         end else begin
            next_count = o_count + 18'h00001;
         end
      end
   end

   // registers, frozen while the clock enable is low
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_count <= WDR_CNT_ZERO;
         o_ovf <= 1'b0;
      end else if (i_ce) begin
         o_count <= next_count;
         o_ovf <= next_ovf;
      end
   end
endmodule

// ---- rtl/wdr_top.sv ----
// watchdog reset unit: restart key, mode register, stop handling, reset request
`timescale 1ns/1ps
module wdr_top
   import wdr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_opt_nonstop,
   input wire logic i_src_run,
   input wire logic i_osc_tick,
   input wire logic i_sys_tick,
   input wire logic i_halt,
   input wire logic i_stop,
   input wire logic i_restart_wr,
   input wire logic [7:0] i_restart_wdata,
   input wire logic i_mode_wr,
   input wire logic [7:0] i_mode_wdata,
   output logic [7:0] o_restart_rdata,
   output logic o_wdt_reset,
   output logic o_counting
);
   // state, mode register, option strap and their next values
   wdr_state_t state, next_state;
   logic [7:0] mode, next_mode;
   logic mode_done, next_mode_done;
   logic nonstop, next_nonstop;
   logic opt_taken, next_opt_taken;
   logic next_wdt_reset, next_counting;
   logic [WDR_CNT_W-1:0] count;
   logic ovf;
   logic bad_key, good_key, second_mode, sleeping, tick, cnt_en, cnt_clr, fire;

   // events and counting conditions
   always_comb begin
      bad_key = i_restart_wr && (i_restart_wdata != WDR_RESTART_KEY);
      good_key = i_restart_wr && (i_restart_wdata == WDR_RESTART_KEY);
      second_mode = i_mode_wr && mode_done;
      sleeping = !nonstop && (i_halt || i_stop);
      // non-stoppable always counts on the oscillator; otherwise the chosen source
      if (nonstop || !mode[WDR_MODE_SRC_BIT]) begin
         tick = i_osc_tick;
      end else begin
         tick = i_sys_tick;
      end
      cnt_en = (state == WDR_ST_RUN) && !sleeping && tick;
      // a pending reset fires in the first cycle the source clock runs
      fire = (state == WDR_ST_PEND) && i_src_run;
      cnt_clr = good_key || fire;
   end

   // interval counter, cleared by a correct key or by the reset pulse
   wdr_counter u_counter (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_clr(cnt_clr),
      .i_en(cnt_en),
      .i_sel(mode[WDR_MODE_SEL_LSB +: 3]),
      .o_count(count),
      .o_ovf(ovf)
   );

   // strap capture and mode register next values
   always_comb begin
      next_opt_taken = 1'b1;
      next_nonstop = opt_taken ? nonstop : i_opt_nonstop;
      next_mode = mode;
      next_mode_done = mode_done;
      // the reset pulse reopens the mode register for one write
      if (fire) begin
         next_mode = WDR_MODE_RST;
         next_mode_done = 1'b0;
      end else if (i_mode_wr && !mode_done) begin
         // upper three bits have no effect on behaviour
         next_mode = i_mode_wdata;
         next_mode_done = 1'b1;
      end
   end

   // state machine next values
   always_comb begin
      next_state = state;
      case (state)
         WDR_ST_RUN: begin
            // any reset event wins over the clock stop bit
            if (bad_key || second_mode || ovf) begin
               next_state = WDR_ST_PEND;
            end else if (!nonstop && mode[WDR_MODE_STOP_BIT]) begin
               next_state = WDR_ST_HALTED;
            end
         end
         WDR_ST_HALTED: begin
            // clearing the stop bit leaves it halted and raises nothing;
            // a wrong key or a second write that keeps the bit set still resets
            if (bad_key || (second_mode && i_mode_wdata[WDR_MODE_STOP_BIT])) begin
               next_state = WDR_ST_PEND;
            end else begin
               next_state = WDR_ST_HALTED;
            end
         end
         WDR_ST_PEND: begin
            // wait here while the source clock is stopped
            if (i_src_run) begin
               next_state = WDR_ST_RUN;
            end
         end
         default: begin
            // unreachable codes fall back to counting
            next_state = WDR_ST_RUN;
         end
      endcase
      // outputs follow the fire and count decisions one cycle later
      next_wdt_reset = fire;
      next_counting = cnt_en;
   end

   // registers, frozen while the clock enable is low
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= WDR_ST_RUN;
         mode <= WDR_MODE_RST;
         mode_done <= 1'b0;
         nonstop <= 1'b0;
         opt_taken <= 1'b0;
         o_wdt_reset <= 1'b0;
         o_counting <= 1'b0;
         o_restart_rdata <= WDR_RESTART_READ;
      end else if (i_ce) begin
         state <= next_state;
         mode <= next_mode;
         mode_done <= next_mode_done;
         nonstop <= next_nonstop;
         opt_taken <= next_opt_taken;
         o_wdt_reset <= next_wdt_reset;
         o_counting <= next_counting;
         o_restart_rdata <= WDR_RESTART_READ;
      end
   end

   // checks
   chk_bad_key: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && bad_key |=> (state == WDR_ST_PEND) || o_wdt_reset)
      else $error("wrong key did not lead to reset");
   chk_defer_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && (state == WDR_ST_PEND) && !i_src_run |=> !o_wdt_reset && state == WDR_ST_PEND)
      else $error("reset issued while source clock halted");
   chk_defer_fire: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && (state == WDR_ST_PEND) && i_src_run |=> o_wdt_reset && count == WDR_CNT_ZERO)
      else $error("pending reset not issued");
   chk_read_value: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_restart_wr |=> ##1 o_restart_rdata == 8'h9A)
      else $error("restart read value wrong");
   chk_nonstop_runs: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && nonstop && i_stop && i_osc_tick && state == WDR_ST_RUN && !cnt_clr
      |=> count != $past(count) || ovf)
      else $error("non-stoppable watchdog halted in stop");
   chk_stop_ovf: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && ovf && state == WDR_ST_RUN |=> state == WDR_ST_PEND || o_wdt_reset)
      else $error("overflow did not lead to reset");
   chk_sleep_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !nonstop && (i_halt || i_stop) && !cnt_clr |=> count == $past(count))
      else $error("count changed in halt or stop");
   chk_second_mode: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_mode_wr && mode_done && state != WDR_ST_PEND
      && !(state == WDR_ST_HALTED && !i_mode_wdata[WDR_MODE_STOP_BIT])
      |=> state == WDR_ST_PEND
      ##1 (o_wdt_reset || !$past(i_src_run) || !$past(i_ce)))
      else $error("second mode write ignored");
   chk_halted_stays: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == WDR_ST_HALTED |=> state != WDR_ST_RUN && !o_wdt_reset)
      else $error("clock stop left without reset");
   chk_key_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && good_key |=> count == WDR_CNT_ZERO)
      else $error("correct key did not clear counter");

   // clock enable, pulse shape, sources and the clock stop bit
   chk_enable_freeze: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !i_ce |=> $stable(state) && $stable(count) && $stable(mode)
      && $stable(o_wdt_reset) && $stable(o_counting))
      else $error("state moved while clock enable low");
   chk_reset_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && o_wdt_reset |=> !o_wdt_reset)
      else $error("internal reset longer than one cycle");
   chk_pend_no_count: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && state == WDR_ST_PEND |=> !o_counting)
      else $error("counting while reset pending");
   chk_nonstop_no_halt: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      nonstop |-> state != WDR_ST_HALTED)
      else $error("non-stoppable watchdog halted");
   chk_sleep_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && !nonstop && (i_halt || i_stop) |=> !o_counting)
      else $error("count taken in halt or stop");
   chk_src_select: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && !nonstop && mode[WDR_MODE_SRC_BIT] && !i_sys_tick
      |=> !o_counting)
      else $error("count taken without selected source tick");
   chk_mode_once: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && i_mode_wr && mode_done |=> mode == $past(mode) || o_wdt_reset)
      else $error("mode register written twice");
   chk_halt_entry: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && state == WDR_ST_RUN && !nonstop && mode[WDR_MODE_STOP_BIT]
      && !bad_key && !second_mode && !ovf |=> state == WDR_ST_HALTED)
      else $error("clock stop bit did not halt");
   chk_stop_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && state == WDR_ST_HALTED && i_mode_wr && !i_mode_wdata[WDR_MODE_STOP_BIT]
      && !bad_key |=> state == WDR_ST_HALTED && !o_counting)
      else $error("clearing clock stop bit restarted the watchdog");
   chk_good_key_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_ce && good_key && state != WDR_ST_PEND && !ovf && !second_mode
      |=> state != WDR_ST_PEND)
      else $error("correct key led to reset");

   // cover points for the main scenarios
   cov_bad_key: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      bad_key && i_ce ##[1:20] o_wdt_reset);
   cov_overflow: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      ovf ##[1:20] o_wdt_reset);
   cov_halted: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      state == WDR_ST_HALTED);
   cov_nonstop_stop: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      nonstop && i_stop && o_counting);
   cov_stop_clear: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      state == WDR_ST_HALTED && i_mode_wr && !i_mode_wdata[WDR_MODE_STOP_BIT]);
endmodule

// ---- sim/tb_top.sv ----
// self-checking testbench of the watchdog reset unit
`timescale 1ns/1ps
module tb_top;
   import wdr_pkg::*;
   logic i_clk = 0, i_sys_rst = 1, i_ce = 1, i_opt_nonstop = 0, i_src_run = 1;
   logic i_osc_tick = 0, i_sys_tick = 0, i_halt = 0, i_stop = 0;
   logic i_restart_wr = 0, i_mode_wr = 0;
   logic [7:0] i_restart_wdata = 8'h00, i_mode_wdata = 8'h00, o_restart_rdata;
   logic o_wdt_reset, o_counting, seen;
   int failures = 0, n_compared = 0;
   wdr_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
      .i_opt_nonstop(i_opt_nonstop), .i_src_run(i_src_run), .i_osc_tick(i_osc_tick),
      .i_sys_tick(i_sys_tick), .i_halt(i_halt), .i_stop(i_stop),
      .i_restart_wr(i_restart_wr), .i_restart_wdata(i_restart_wdata),
      .i_mode_wr(i_mode_wr), .i_mode_wdata(i_mode_wdata),
      .o_restart_rdata(o_restart_rdata), .o_wdt_reset(o_wdt_reset), .o_counting(o_counting));
   // 40 MHz clock
   always #12.5 i_clk = ~i_clk;
   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // n cycles with the given tick pattern (bit0 osc, bit1 alt); notes any reset pulse
   task automatic run(input int n, input logic [1:0] tk, output logic s);
      s = 0;
      repeat (n) begin
         @(posedge i_clk);
         #2;
         if (o_wdt_reset === 1'b1) s = 1;
         i_osc_tick = tk[0];
         i_sys_tick = tk[1];
         i_restart_wr = 0;
         i_mode_wr = 0;
      end
   endtask
   task automatic wr_restart(input logic [7:0] d);
      @(posedge i_clk);
      #2;
      i_restart_wr = 1;
      i_restart_wdata = d;
      @(posedge i_clk);
      #2;
      i_restart_wr = 0;
   endtask
   task automatic wr_mode(input logic [7:0] d);
      @(posedge i_clk);
      #2;
      i_mode_wr = 1;
      i_mode_wdata = d;
      @(posedge i_clk);
      #2;
      i_mode_wr = 0;
   endtask
   task automatic step_set(ref logic sig, input logic v);
      @(posedge i_clk);
      #2;
      sig = v;
   endtask
   task automatic do_reset(input int n);
      step_set(i_sys_rst, 1'b1);
      run(n, 2'b00, seen);
      step_set(i_sys_rst, 1'b0);
      run(3, 2'b00, seen);
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // restart keys: good key quiet, bad key fires, read value fixed
   task automatic t_keys();
      chk_byte("read value", 8'h9A, o_restart_rdata);
      wr_restart(WDR_RESTART_KEY);
      run(20, 2'b00, seen);
      chk_bit("good key reset", 1'b0, seen);
      wr_restart(8'h55);
      run(6, 2'b00, seen);
      chk_bit("bad key reset", 1'b1, seen);
      chk_byte("read after write", 8'h9A, o_restart_rdata);
      $display("test keys done");
   endtask
   // clock enable low freezes the block: a write is not taken
   task automatic t_freeze();
      step_set(i_ce, 1'b0);
      wr_restart(8'h55);
      run(6, 2'b00, seen);
      chk_bit("frozen reset", 1'b0, seen);
      step_set(i_ce, 1'b1);
      run(6, 2'b00, seen);
      chk_bit("write while frozen", 1'b0, seen);
      $display("test freeze done");
   endtask
   // bad key while source clock halted waits for it
   task automatic t_defer();
      step_set(i_src_run, 1'b0);
      wr_restart(8'h00);
      run(20, 2'b00, seen);
      chk_bit("deferred reset early", 1'b0, seen);
      step_set(i_src_run, 1'b1);
      run(6, 2'b00, seen);
      chk_bit("deferred reset late", 1'b1, seen);
      $display("test defer done");
   endtask
   // second mode write fires reset
   task automatic t_mode2();
      wr_mode(8'h60);
      run(4, 2'b00, seen);
      chk_bit("first mode write", 1'b0, seen);
      wr_mode(8'h60);
      run(6, 2'b00, seen);
      chk_bit("second mode write", 1'b1, seen);
      $display("test mode done");
   endtask
   // stoppable: halt freezes count, source and count kept after halt
   task automatic t_hold();
      wr_mode(8'h68);
      run(600, 2'b10, seen);
      chk_bit("before halt", 1'b0, seen);
      step_set(i_halt, 1'b1);
      run(300, 2'b10, seen);
      chk_bit("during halt", 1'b0, seen);
      chk_bit("counting in halt", 1'b0, o_counting);
      step_set(i_stop, 1'b1);
      step_set(i_halt, 1'b0);
      run(300, 2'b10, seen);
      chk_bit("during stop", 1'b0, seen);
      chk_bit("counting while stopped", 1'b0, o_counting);
      step_set(i_stop, 1'b0);
      run(500, 2'b01, seen);
      chk_bit("other source", 1'b0, seen);
      run(300, 2'b10, seen);
      chk_bit("held count", 1'b0, seen);
      run(200, 2'b10, seen);
      chk_bit("overflow after halt", 1'b1, seen);
      $display("test hold done");
   endtask
   // clock stop bit halts counting with no reset
   task automatic t_stopbit();
      wr_mode(8'h70);
      run(1100, 2'b01, seen);
      chk_bit("stopped reset", 1'b0, seen);
      chk_bit("stopped counting", 1'b0, o_counting);
      wr_mode(8'h60);
      run(1100, 2'b01, seen);
      chk_bit("cleared stop reset", 1'b0, seen);
      chk_bit("cleared stop counting", 1'b0, o_counting);
      wr_restart(8'h00);
      run(6, 2'b01, seen);
      chk_bit("bad key while halted", 1'b1, seen);
      $display("test stop bit done");
   endtask
   // non-stoppable: counts and overflows in stop
   task automatic t_nonstop();
      i_opt_nonstop = 1;
      do_reset(4);
      wr_mode(8'hF8);
      step_set(i_stop, 1'b1);
      run(10, 2'b01, seen);
      chk_bit("counting in stop", 1'b1, o_counting);
      repeat (2) begin
         run(900, 2'b01, seen);
         chk_bit("serviced in stop", 1'b0, seen);
         wr_restart(WDR_RESTART_KEY);
      end
      run(1100, 2'b01, seen);
      chk_bit("overflow in stop", 1'b1, seen);
      $display("test nonstop done");
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge i_clk);
      #2;
      i_sys_rst = 0;
      run(3, 2'b00, seen);
      chk_bit("reset idle", 1'b0, o_wdt_reset);
      t_keys();
      t_freeze();
      t_defer();
      t_mode2();
      t_hold();
      t_stopbit();
      t_nonstop();
      tally_and_finish();
   end
endmodule
